/* src/mtr_consts.vh */
`ifndef MTR_CONSTS_VH
`define MTR_CONSTS_VH

// Trap type codes.
`define MTR_TT_I_MISS        9'h064
`define MTR_TT_I_ACC_EXC     9'h008
`define MTR_TT_I_ACC_ERR     9'h00A
`define MTR_TT_D_MISS        9'h068
`define MTR_TT_D_ACC_EXC     9'h030
`define MTR_TT_D_PROT        9'h06C
`define MTR_TT_PRIV_ACTION   9'h037
`define MTR_TT_PA_WATCH      9'h061
`define MTR_TT_VA_WATCH      9'h062
`define MTR_TT_MISALIGN      9'h035
`define MTR_TT_MIS_LDDF      9'h036
`define MTR_TT_MIS_STDF      9'h038
`define MTR_TT_MIS_LDQF      9'h039
`define MTR_TT_D_ACC_ERR     9'h032
`define MTR_TT_PAGE_CROSS    9'h077

// Fault status word layout.
`define MTR_FS_FV            0
`define MTR_FS_OW            1
`define MTR_FS_W             2
`define MTR_FS_EXT           3
`define MTR_FS_FT_LO         8
`define MTR_FS_FT_HI         15
`define MTR_FS_TT_LO         16
`define MTR_FS_TT_HI         24
// Fault type codes.
`define MTR_FT_NONE          8'h00
`define MTR_FT_PRIV_PAGE     8'h01
`define MTR_FT_OTHER         8'h02
`define MTR_FT_MULTI_HIT     8'h04
`define MTR_FT_UE            8'h08
`define MTR_FT_BUS           8'h10

// Control register bits and reset value.
`define MTR_CTL_REC_EN       0
`define MTR_CTL_WATCH_OVR    1
`define MTR_CTL_RESET        32'h0000_0003

// Register byte offsets.
`define MTR_OFF_CTRL         8'h00
`define MTR_OFF_ISFS         8'h04
`define MTR_OFF_ITAG_LO      8'h08
`define MTR_OFF_ITAG_HI      8'h0C
`define MTR_OFF_DSFS         8'h10
`define MTR_OFF_DFA_LO       8'h14
`define MTR_OFF_DFA_HI       8'h18
`define MTR_OFF_DTAG_LO      8'h1C
`define MTR_OFF_DTAG_HI      8'h20
`define MTR_OFF_TAG_EXT      8'h24
`define MTR_OFF_LAST_TT      8'h28

`define MTR_CTX_W            13
`endif

/* src/mtr_ihalf.v */
`timescale 1ns/1ns
`include "mtr_consts.vh"
module mtr_ihalf (
  // Fetch fault inputs
  input  wire       miss_i,
  input  wire       acc_exc_i,
  input  wire       priv_page_i,
  input  wire       ue_i,
  input  wire       bus_err_i,
  input  wire       multi_hit_i,
  // Decision
  output reg        hit_o,
  output reg  [8:0] tt_o,
  output reg  [7:0] ft_o,
  output reg        upd_tag_o
);
  always @* begin
    hit_o     = 1'b1;
    tt_o      = `MTR_TT_I_ACC_ERR;
    ft_o      = `MTR_FT_NONE;
    upd_tag_o = 1'b0;
    // Multiple hit leaves no entry, so entry checks are ignored then.
    if (multi_hit_i) begin
      ft_o = `MTR_FT_MULTI_HIT;
    end else if (miss_i) begin
      tt_o      = `MTR_TT_I_MISS;
      upd_tag_o = 1'b1;
    end else if (acc_exc_i || priv_page_i) begin
      tt_o      = `MTR_TT_I_ACC_EXC;
      upd_tag_o = 1'b1;
      ft_o      = priv_page_i ? `MTR_FT_PRIV_PAGE : `MTR_FT_OTHER;
    end else if (ue_i) begin
      ft_o = `MTR_FT_UE;
    end else if (bus_err_i) begin
      ft_o = `MTR_FT_BUS;
    end else begin
      hit_o = 1'b0;
    end
  end
endmodule

/* src/mtr_dhalf.v */
`timescale 1ns/1ns
`include "mtr_consts.vh"
module mtr_dhalf #(
  parameter EXT = 0
) (
  // Data fault inputs of one half
  input  wire       priv_asi_i,
  input  wire       misalign_i,
  input  wire [1:0] mis_kind_i,
  input  wire       va_watch_i,
  input  wire       miss_i,
  input  wire       acc_exc_i,
  input  wire       priv_page_i,
  input  wire       prot_i,
  input  wire       pa_watch_i,
  input  wire       ue_i,
  input  wire       bus_to_i,
  input  wire       multi_hit_i,
  // Decision
  output reg        hit_o,
  output reg        lvl12_o,
  output reg  [8:0] tt_o,
  output reg  [7:0] ft_o,
  output reg        upd_tag_o,
  output reg        ctx_undef_o
);
  always @* begin
    hit_o       = 1'b1;
    lvl12_o     = 1'b0;
    tt_o        = `MTR_TT_D_ACC_ERR;
    ft_o        = `MTR_FT_NONE;
    upd_tag_o   = 1'b0;
    ctx_undef_o = 1'b0;
    if (priv_asi_i) begin
      tt_o = `MTR_TT_PRIV_ACTION;
    end else if (misalign_i) begin
      case (mis_kind_i)
        2'd0: tt_o = `MTR_TT_MISALIGN;
        2'd1: tt_o = `MTR_TT_MIS_LDDF;
        2'd2: tt_o = `MTR_TT_MIS_STDF;
        default: tt_o = `MTR_TT_MIS_LDQF;
      endcase
    end else if (va_watch_i) begin
      tt_o = `MTR_TT_VA_WATCH;
    end else if (multi_hit_i) begin
      lvl12_o = 1'b1;
      ft_o    = `MTR_FT_MULTI_HIT;
    end else if (miss_i) begin
      lvl12_o = 1'b1;
      // The extended half reports a page crossing and keeps the tag.
      tt_o      = EXT ? `MTR_TT_PAGE_CROSS : `MTR_TT_D_MISS;
      upd_tag_o = EXT ? 1'b0 : 1'b1;
    end else if (acc_exc_i || priv_page_i) begin
      lvl12_o     = 1'b1;
      tt_o        = `MTR_TT_D_ACC_EXC;
      upd_tag_o   = 1'b1;
      ctx_undef_o = 1'b1;
      ft_o        = priv_page_i ? `MTR_FT_PRIV_PAGE : `MTR_FT_OTHER;
    end else if (prot_i) begin
      lvl12_o   = 1'b1;
      tt_o      = `MTR_TT_D_PROT;
      upd_tag_o = 1'b1;
    end else if (pa_watch_i) begin
      tt_o = `MTR_TT_PA_WATCH;
    end else if (ue_i) begin
      lvl12_o = 1'b1;
      ft_o    = `MTR_FT_UE;
    end else if (bus_to_i) begin
      lvl12_o = 1'b1;
      ft_o    = `MTR_FT_BUS;
    end else begin
      hit_o = 1'b0;
    end
  end
endmodule

/* src/mtr_trap_rec.v */
`timescale 1ns/1ns
`include "mtr_consts.vh"
module mtr_trap_rec (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Fetch side faults
  input  wire        i_commit_i,
  input  wire [63:0] i_va_i,
  input  wire [12:0] i_ctx_i,
  input  wire        i_miss_i,
  input  wire        i_acc_exc_i,
  input  wire        i_priv_page_i,
  input  wire        i_ue_i,
  input  wire        i_bus_err_i,
  input  wire        i_multi_hit_i,
  // Load-store side common
  input  wire        d_commit_i,
  input  wire        d_write_i,
  input  wire        d_vector_i,
  input  wire [12:0] d_ctx_i,
  input  wire [31:0] d_tag_ext_i,
  input  wire        d_priv_asi_i,
  input  wire        d_misalign_i,
  input  wire [1:0]  d_mis_kind_i,
  input  wire        d_mis_jump_i,
  // Basic half
  input  wire [63:0] b_va_i,
  input  wire        b_va_watch_i,
  input  wire        b_miss_i,
  input  wire        b_acc_exc_i,
  input  wire        b_priv_page_i,
  input  wire        b_prot_i,
  input  wire        b_pa_watch_i,
  input  wire        b_ue_i,
  input  wire        b_bus_to_i,
  input  wire        b_multi_hit_i,
  // Extended half
  input  wire [63:0] x_va_i,
  input  wire        x_va_watch_i,
  input  wire        x_miss_i,
  input  wire        x_acc_exc_i,
  input  wire        x_priv_page_i,
  input  wire        x_prot_i,
  input  wire        x_pa_watch_i,
  input  wire        x_ue_i,
  input  wire        x_bus_to_i,
  input  wire        x_multi_hit_i,
  // Trap to pipeline
  output reg         trap_valid_o,
  output reg  [8:0]  trap_type_o
);

  reg  [31:0] ctrl;
  reg  [31:0] instr_fault_status;
  reg  [63:0] instr_tag_access;
  reg  [31:0] data_fault_status;
  reg  [63:0] data_fault_address;
  reg  [63:0] data_tag_access;
  reg  [31:0] tlb_tag_access_extension;
  reg  [8:0]  last_tt;

  wire        i_hit;
  wire [8:0]  i_tt;
  wire [7:0]  i_ft;
  wire        i_upd_tag;
  wire        b_hit;
  wire        b_lvl12;
  wire [8:0]  b_tt;
  wire [7:0]  b_ft;
  wire        b_upd_tag;
  wire        b_ctx_undef;
  wire        x_hit;
  wire        x_lvl12;
  wire [8:0]  x_tt;
  wire [7:0]  x_ft;
  wire        x_upd_tag;
  wire        x_ctx_undef;

  // Builds one fault status word; the valid bit is always set.
  function [31:0] fs_word;
    input       ow;
    input       wr;
    input       ext;
    input [7:0] ft;
    input [8:0] tt;
    begin
      fs_word                              = 32'h0000_0000;
      fs_word[`MTR_FS_FV]                  = 1'b1;
      fs_word[`MTR_FS_OW]                  = ow;
      fs_word[`MTR_FS_W]                   = wr;
      fs_word[`MTR_FS_EXT]                 = ext;
      fs_word[`MTR_FS_FT_HI:`MTR_FS_FT_LO] = ft;
      fs_word[`MTR_FS_TT_HI:`MTR_FS_TT_LO] = tt;
    end
  endfunction

  // Byte-lane merge for software writes.
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer      k;
    begin
      lane_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          lane_merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  mtr_ihalf u_ihalf (
    .miss_i      (i_miss_i),
    .acc_exc_i   (i_acc_exc_i),
    .priv_page_i (i_priv_page_i),
    .ue_i        (i_ue_i),
    .bus_err_i   (i_bus_err_i),
    .multi_hit_i (i_multi_hit_i),
    .hit_o       (i_hit),
    .tt_o        (i_tt),
    .ft_o        (i_ft),
    .upd_tag_o   (i_upd_tag)
  );

  // Instruction-wide checks belong to the basic half only.
  mtr_dhalf #(.EXT(0)) u_bhalf (
    .priv_asi_i  (d_priv_asi_i),
    .misalign_i  (d_misalign_i),
    .mis_kind_i  (d_mis_kind_i),
    .va_watch_i  (b_va_watch_i),
    .miss_i      (b_miss_i),
    .acc_exc_i   (b_acc_exc_i),
    .priv_page_i (b_priv_page_i),
    .prot_i      (b_prot_i),
    .pa_watch_i  (b_pa_watch_i),
    .ue_i        (b_ue_i),
    .bus_to_i    (b_bus_to_i),
    .multi_hit_i (b_multi_hit_i),
    .hit_o       (b_hit),
    .lvl12_o     (b_lvl12),
    .tt_o        (b_tt),
    .ft_o        (b_ft),
    .upd_tag_o   (b_upd_tag),
    .ctx_undef_o (b_ctx_undef)
  );

  mtr_dhalf #(.EXT(1)) u_xhalf (
    .priv_asi_i  (1'b0),
    .misalign_i  (1'b0),
    .mis_kind_i  (2'b00),
    .va_watch_i  (x_va_watch_i & d_vector_i),
    .miss_i      (x_miss_i & d_vector_i),
    .acc_exc_i   (x_acc_exc_i & d_vector_i),
    .priv_page_i (x_priv_page_i & d_vector_i),
    .prot_i      (x_prot_i & d_vector_i),
    .pa_watch_i  (x_pa_watch_i & d_vector_i),
    .ue_i        (x_ue_i & d_vector_i),
    .bus_to_i    (x_bus_to_i & d_vector_i),
    .multi_hit_i (x_multi_hit_i & d_vector_i),
    .hit_o       (x_hit),
    .lvl12_o     (x_lvl12),
    .tt_o        (x_tt),
    .ft_o        (x_ft),
    .upd_tag_o   (x_upd_tag),
    .ctx_undef_o (x_ctx_undef)
  );

  // Basic half first; an extended Virtual_addr_watch_trap may
  // overtake a basic level-12 fault if enabled.
  wire watch_ovr = ctrl[`MTR_CTL_WATCH_OVR] & d_vector_i & x_va_watch_i &
                   b_lvl12;
  wire use_x     = x_hit & (~b_hit | watch_ovr);
  wire d_hit     = b_hit | x_hit;
  wire [8:0] d_tt        = use_x ? x_tt : b_tt;
  wire [7:0] d_ft        = use_x ? x_ft : b_ft;
  wire       d_upd_tag   = use_x ? x_upd_tag : b_upd_tag;
  wire       d_ctx_undef = use_x ? x_ctx_undef : b_ctx_undef;
  wire [63:0] d_addr     = use_x ? x_va_i : b_va_i;
  // Jump and return misalignment reports the trap and records only last_tt.
  wire d_is_jmp_mis = ~use_x & d_misalign_i & ~d_priv_asi_i & d_mis_jump_i;

  // A fetch fault is older than any data fault committing alongside it.
  wire take_i = i_commit_i & i_hit;
  wire take_d = d_commit_i & d_hit & ~take_i;
  wire rec_en = ctrl[`MTR_CTL_REC_EN];

  // Bus access decode.
  wire        bus_req = cyc_i & stb_i & ~ack_o;
  wire        bus_wr  = cyc_i & stb_i & ack_o & we_i;
  reg  [31:0] next_rdata;

  always @* begin
    if (adr_i == `MTR_OFF_CTRL) begin
      next_rdata = ctrl;
    end else if (adr_i == `MTR_OFF_ISFS) begin
      next_rdata = instr_fault_status;
    end else if (adr_i == `MTR_OFF_ITAG_LO) begin
      next_rdata = instr_tag_access[31:0];
    end else if (adr_i == `MTR_OFF_ITAG_HI) begin
      next_rdata = instr_tag_access[63:32];
    end else if (adr_i == `MTR_OFF_DSFS) begin
      next_rdata = data_fault_status;
    end else if (adr_i == `MTR_OFF_DFA_LO) begin
      next_rdata = data_fault_address[31:0];
    end else if (adr_i == `MTR_OFF_DFA_HI) begin
      next_rdata = data_fault_address[63:32];
    end else if (adr_i == `MTR_OFF_DTAG_LO) begin
      next_rdata = data_tag_access[31:0];
    end else if (adr_i == `MTR_OFF_DTAG_HI) begin
      next_rdata = data_tag_access[63:32];
    end else if (adr_i == `MTR_OFF_TAG_EXT) begin
      next_rdata = tlb_tag_access_extension;
    end else if (adr_i == `MTR_OFF_LAST_TT) begin
      next_rdata = {23'h00_0000, last_tt};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // Answer one cycle after the request; read data is captured with ack.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= next_rdata;
      end
    end
  end

  // Trap output, one pulse per taken fault.
  always @(posedge clk_i) begin
    if (rst_i) begin
      trap_valid_o <= 1'b0;
      trap_type_o  <= 9'h000;
      last_tt      <= 9'h000;
    end else begin
      trap_valid_o <= take_i | take_d;
      if (take_i) begin
        trap_type_o <= i_tt;
        last_tt     <= i_tt;
      end else if (take_d) begin
        trap_type_o <= d_tt;
        last_tt     <= d_tt;
      end
    end
  end

  // Control register.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `MTR_CTL_RESET;
    end else if (bus_wr && adr_i == `MTR_OFF_CTRL) begin
      ctrl <= lane_merge(ctrl, dat_i, sel_i) & 32'h0000_0003;
    end
  end

  // Writing one to the valid bit clears it;
  // a fault recorded in the same cycle (rec_en set) wins.
  always @(posedge clk_i) begin
    if (rst_i) begin
      instr_fault_status <= 32'h0000_0000;
      instr_tag_access   <= 64'h0000_0000_0000_0000;
    end else if (take_i && rec_en) begin
      instr_fault_status <= fs_word(instr_fault_status[`MTR_FS_FV], 1'b0, 1'b0,
                                    i_ft, i_tt);
      if (i_upd_tag) begin
        instr_tag_access <= {i_va_i[63:13], i_ctx_i};
      end
    end else if (bus_wr && adr_i == `MTR_OFF_ISFS && sel_i[0] &&
                 dat_i[`MTR_FS_FV]) begin
      instr_fault_status[`MTR_FS_FV] <= 1'b0;
    end
  end

  // Data fault state.
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_fault_status        <= 32'h0000_0000;
      data_fault_address       <= 64'h0000_0000_0000_0000;
      data_tag_access          <= 64'h0000_0000_0000_0000;
      tlb_tag_access_extension <= 32'h0000_0000;
    end else if (take_d && rec_en && !d_is_jmp_mis) begin
      data_fault_status  <= fs_word(data_fault_status[`MTR_FS_FV], d_write_i, use_x,
                                    d_ft, d_tt);
      data_fault_address <= d_addr;
      if (d_upd_tag) begin
        // Context is zeroed where its value is undefined.
        data_tag_access <= {d_addr[63:13],
                            d_ctx_undef ? 13'h0000 : d_ctx_i};
        tlb_tag_access_extension <= d_tag_ext_i;
      end
    end else if (bus_wr && adr_i == `MTR_OFF_DSFS && sel_i[0] &&
                 dat_i[`MTR_FS_FV]) begin
      data_fault_status[`MTR_FS_FV] <= 1'b0;
    end
  end


endmodule

/* sim/mtr_trap_rec_assertions.sv */
`timescale 1ns/1ns
`include "mtr_consts.vh"
module mtr_trap_rec_assertions (
  // Clock, reset and bus handshake
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       cyc_i,
  input  wire       stb_i,
  input  wire       ack_o,
  // Fetch side
  input  wire       i_commit_i,
  input  wire       i_miss_i,
  input  wire       i_acc_exc_i,
  input  wire       i_priv_page_i,
  input  wire       i_ue_i,
  input  wire       i_bus_err_i,
  input  wire       i_multi_hit_i,
  // Load-store side
  input  wire       d_commit_i,
  input  wire       d_vector_i,
  input  wire       d_priv_asi_i,
  input  wire       d_misalign_i,
  input  wire [1:0] d_mis_kind_i,
  input  wire       b_va_watch_i,
  input  wire       b_miss_i,
  input  wire       b_acc_exc_i,
  input  wire       b_priv_page_i,
  input  wire       b_prot_i,
  input  wire       b_pa_watch_i,
  input  wire       b_ue_i,
  input  wire       b_bus_to_i,
  input  wire       b_multi_hit_i,
  input  wire       x_va_watch_i,
  input  wire       x_miss_i,
  input  wire       x_multi_hit_i,
  // Trap output
  input  wire       trap_valid_o,
  input  wire [8:0] trap_type_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire       i_any = i_miss_i | i_acc_exc_i | i_priv_page_i | i_ue_i | i_bus_err_i
                     | i_multi_hit_i;
  wire       b_any = b_va_watch_i | b_miss_i | b_acc_exc_i | b_priv_page_i | b_prot_i
                     | b_pa_watch_i | b_ue_i | b_bus_to_i | b_multi_hit_i;
  wire [8:0] mis_tt = (d_mis_kind_i == 2'h0) ? `MTR_TT_MISALIGN :
                      (d_mis_kind_i == 2'h1) ? `MTR_TT_MIS_LDDF :
                      (d_mis_kind_i == 2'h2) ? `MTR_TT_MIS_STDF : `MTR_TT_MIS_LDQF;
  wire       d_take = d_commit_i && !(i_commit_i && i_any);
  sequence s_dtake;
    d_take && !d_priv_asi_i && !d_misalign_i;
  endsequence
  sequence s_trap(logic [8:0] code);
    trap_valid_o && trap_type_o == code;
  endsequence
  property p_ack_one;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i && !ack_o);
  endproperty
  property p_quiet;
    !i_commit_i && !d_commit_i |=> !trap_valid_o;
  endproperty
  property p_imiss;
    i_commit_i && i_miss_i && !(i_acc_exc_i || i_priv_page_i || i_ue_i || i_bus_err_i
      || i_multi_hit_i) |=> s_trap(`MTR_TT_I_MISS);
  endproperty
  property p_iexc;
    i_commit_i && (i_acc_exc_i || i_priv_page_i) && !i_miss_i && !i_ue_i && !i_bus_err_i
      && !i_multi_hit_i |=> s_trap(`MTR_TT_I_ACC_EXC);
  endproperty
  property p_ierr;
    i_commit_i && (i_ue_i || i_bus_err_i || i_multi_hit_i) && !i_miss_i && !i_acc_exc_i
      && !i_priv_page_i |=> s_trap(`MTR_TT_I_ACC_ERR);
  endproperty
  property p_priv;
    d_take && d_priv_asi_i |=> s_trap(`MTR_TT_PRIV_ACTION);
  endproperty
  property p_mis;
    d_take && !d_priv_asi_i && d_misalign_i |=> trap_valid_o && trap_type_o == $past(mis_tt);
  endproperty
  property p_dmh;
    s_dtake ##0 !b_va_watch_i && b_multi_hit_i && !x_va_watch_i |=> s_trap(`MTR_TT_D_ACC_ERR);
  endproperty
  property p_dmiss;
    s_dtake ##0 b_miss_i && !b_va_watch_i && !b_multi_hit_i && !x_va_watch_i
      |=> s_trap(`MTR_TT_D_MISS);
  endproperty
  property p_xcross;
    s_dtake ##0 d_vector_i && !b_any && x_miss_i && !x_va_watch_i && !x_multi_hit_i
      |=> s_trap(`MTR_TT_PAGE_CROSS);
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not one pulse");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_quiet: assert property (p_quiet) else $error("trap without commit");
  a_imiss: assert property (p_imiss) else $error("fetch miss trap wrong");
  a_iexc: assert property (p_iexc) else $error("fetch exc trap wrong");
  a_ierr: assert property (p_ierr) else $error("fetch error trap wrong");
  a_priv: assert property (p_priv) else $error("priv action trap wrong");
  a_mis: assert property (p_mis) else $error("misalign trap wrong");
  a_dmh: assert property (p_dmh) else $error("multi hit trap wrong");
  a_dmiss: assert property (p_dmiss) else $error("data miss trap wrong");
  a_xcross: assert property (p_xcross) else $error("page cross trap wrong");
endmodule
bind mtr_trap_rec mtr_trap_rec_assertions chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .i_commit_i(i_commit_i), .i_miss_i(i_miss_i), .i_acc_exc_i(i_acc_exc_i),
  .i_priv_page_i(i_priv_page_i), .i_ue_i(i_ue_i), .i_bus_err_i(i_bus_err_i),
  .i_multi_hit_i(i_multi_hit_i), .d_commit_i(d_commit_i), .d_vector_i(d_vector_i),
  .d_priv_asi_i(d_priv_asi_i), .d_misalign_i(d_misalign_i), .d_mis_kind_i(d_mis_kind_i),
  .b_va_watch_i(b_va_watch_i), .b_miss_i(b_miss_i), .b_acc_exc_i(b_acc_exc_i),
  .b_priv_page_i(b_priv_page_i), .b_prot_i(b_prot_i), .b_pa_watch_i(b_pa_watch_i),
  .b_ue_i(b_ue_i), .b_bus_to_i(b_bus_to_i), .b_multi_hit_i(b_multi_hit_i),
  .x_va_watch_i(x_va_watch_i), .x_miss_i(x_miss_i), .x_multi_hit_i(x_multi_hit_i),
  .trap_valid_o(trap_valid_o), .trap_type_o(trap_type_o)
);

/* sim/mtr_pipe_model.sv */
`timescale 1ns/1ns
module mtr_pipe_model (
  // Clock
  input  wire        clk_i,
  // Causes: fetch, basic half, extended half, access modifiers
  output reg  [5:0]  ic_o,
  output reg  [8:0]  b_o,
  output reg  [8:0]  x_o,
  output reg  [7:0]  m_o,
  // Commit strobes
  output reg         i_commit_o,
  output reg         d_commit_o,
  // Addresses and contexts
  output reg  [63:0] i_va_o,
  output reg  [63:0] b_va_o,
  output reg  [63:0] x_va_o,
  output reg  [12:0] i_ctx_o,
  output reg  [12:0] d_ctx_o
);
  initial begin
    {ic_o, b_o, x_o, m_o, i_commit_o, d_commit_o} = 34'h0;
    {i_va_o, b_va_o, x_va_o, i_ctx_o, d_ctx_o} = 218'h0;
  end
  // Bit 7 of m squashes; addresses invert afterwards so stale reads never match.
  task automatic fault(input [5:0] ic, input [8:0] b, input [8:0] x, input [7:0] m,
                       input [7:0] n);
    begin
      @(posedge clk_i);
      {ic_o, b_o, x_o, m_o} <= {ic, b, x, m};
      i_commit_o <= (|ic) & ~m[7];
      d_commit_o <= (|{b, x, m[1:0]}) & ~m[7];
      i_va_o <= {32'h0000_0001, 8'hA0, 3'h0, n, 13'h0000};
      b_va_o <= {32'h0000_0001, 8'hB0, 3'h0, n, 13'h0000};
      x_va_o <= {32'h0000_0001, 8'hC0, 3'h0, n, 13'h0000};
      i_ctx_o <= {5'h0A, n};
      d_ctx_o <= {5'h15, n};
      @(posedge clk_i);
      {ic_o, b_o, x_o, m_o, i_commit_o, d_commit_o} <= 34'h0;
      {i_va_o, b_va_o, x_va_o} <= ~{i_va_o, b_va_o, x_va_o};
      {i_ctx_o, d_ctx_o} <= ~{i_ctx_o, d_ctx_o};
    end
  endtask
endmodule

/* sim/mtr_trap_rec_tb.sv */
`timescale 1ns/1ns
`include "mtr_consts.vh"
module mtr_trap_rec_tb;
  localparam [8:0] NN = 9'h000, H_VW = 9'h100, H_MS = 9'h080, H_AE = 9'h040;
  localparam [8:0] H_PP = 9'h020, H_PR = 9'h010, H_PW = 9'h008, H_UE = 9'h004;
  localparam [8:0] H_BT = 9'h002, H_MH = 9'h001;
  reg         clk_i;
  reg         rst_i;
  reg         cyc, stb, we;
  reg  [7:0]  adr;
  reg  [31:0] wdat;
  reg  [3:0]  sel;
  wire [31:0] rdat;
  wire        ack, trap_v, icm, dcm;
  wire [8:0]  trap_tt, b, x;
  wire [5:0]  ic;
  wire [7:0]  m;
  wire [63:0] iva, bva, xva;
  wire [12:0] ictx, dctx;
  integer     num_errors = 0;
  integer     tests_run = 0;
  reg  [7:0]  n;
  reg  [31:0] q, e_isfs, e_imsk, e_itag, e_dsfs, e_dmsk, e_dfa, e_dtag, e_tmsk;

  mtr_pipe_model pipe (
    .clk_i(clk_i), .ic_o(ic), .b_o(b), .x_o(x), .m_o(m), .i_commit_o(icm),
    .d_commit_o(dcm), .i_va_o(iva), .b_va_o(bva), .x_va_o(xva), .i_ctx_o(ictx),
    .d_ctx_o(dctx));
  mtr_trap_rec dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .i_commit_i(icm),
    .i_va_i(iva), .i_ctx_i(ictx), .i_miss_i(ic[5]), .i_acc_exc_i(ic[4]),
    .i_priv_page_i(ic[3]), .i_ue_i(ic[2]), .i_bus_err_i(ic[1]), .i_multi_hit_i(ic[0]),
    .d_commit_i(dcm), .d_write_i(m[6]), .d_vector_i(m[5]), .d_ctx_i(dctx),
    .d_tag_ext_i(32'h0000_0000), .d_priv_asi_i(m[0]), .d_misalign_i(m[1]),
    .d_mis_kind_i(m[3:2]), .d_mis_jump_i(m[4]), .b_va_i(bva), .b_va_watch_i(b[8]),
    .b_miss_i(b[7]), .b_acc_exc_i(b[6]), .b_priv_page_i(b[5]), .b_prot_i(b[4]),
    .b_pa_watch_i(b[3]), .b_ue_i(b[2]), .b_bus_to_i(b[1]), .b_multi_hit_i(b[0]),
    .x_va_i(xva), .x_va_watch_i(x[8]), .x_miss_i(x[7]), .x_acc_exc_i(x[6]),
    .x_priv_page_i(x[5]), .x_prot_i(x[4]), .x_pa_watch_i(x[3]), .x_ue_i(x[2]),
    .x_bus_to_i(x[1]), .x_multi_hit_i(x[0]), .trap_valid_o(trap_v), .trap_type_o(trap_tt));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic cmp(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One classic cycle, held until ack is sampled high.
  task automatic wb(input w, input [7:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
      t = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && t < 20) begin
        @(posedge clk_i);
        t = t + 1;
      end
      if (t == 20) cmp(32'h0000_0000, 32'h0000_0001);
      q = rdat;
      {cyc, stb} <= 2'b00;
    end
  endtask

  task automatic rc(input [7:0] a, input [31:0] e, input [31:0] k);
    begin
      wb(1'b0, a, 32'h0000_0000);
      cmp(q & k, e & k);
    end
  endtask

  // ft FF skips fault type; u bits 4..0: ext half, I tag, I status, D tag, D status.
  task automatic run(input [5:0] ic_v, input [8:0] b_v, input [8:0] x_v, input [7:0] m_v,
                     input [8:0] tt_v, input [7:0] ft_v, input [4:0] u);
    reg [31:0] fa;
    reg [31:0] ms;
    begin
      n = n + 8'h01;
      pipe.fault(ic_v, b_v, x_v, m_v, n);
      #1;
      cmp({31'h0, trap_v}, {31'h0, tt_v != 9'h000});
      if (tt_v != 9'h000) cmp({23'h0, trap_tt}, {23'h0, tt_v});
      ms = (ft_v == 8'hFF) ? 32'h01FF_000D : 32'h01FF_FF0D;
      fa = {u[4] ? 8'hC0 : 8'hB0, 3'h0, n, 13'h0000};
      if (u[2]) {e_isfs, e_imsk} = {7'h0, tt_v, ft_v, 8'h01, ms};
      if (u[3]) e_itag = {8'hA0, 3'h0, n, 5'h0A, n};
      if (u[0]) {e_dsfs, e_dmsk, e_dfa} = {7'h0, tt_v, ft_v, 4'h0, u[4], m_v[6], 2'b01, ms, fa};
      if (u[1]) e_dtag = {fa[31:13], 5'h15, n};
      if (u[1]) e_tmsk = (tt_v == `MTR_TT_D_ACC_EXC) ? 32'hFFFF_E000 : 32'hFFFF_FFFF;
      rc(`MTR_OFF_ISFS, e_isfs, e_imsk);
      rc(`MTR_OFF_ITAG_LO, e_itag, 32'hFFFF_FFFF);
      rc(`MTR_OFF_DSFS, e_dsfs, e_dmsk);
      rc(`MTR_OFF_DFA_LO, e_dfa, 32'hFFFF_FFFF);
      rc(`MTR_OFF_DTAG_LO, e_dtag, e_tmsk);
      $display("Test %0d done", n);
    end
  endtask

  task end_sim;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  initial begin
    {rst_i, cyc, stb, we, adr, wdat, sel, n} = {1'b1, 43'h0, 4'hF, 8'h00};
    {e_isfs, e_itag, e_dsfs, e_dfa, e_dtag} = 160'h0;
    {e_imsk, e_dmsk, e_tmsk} = {3{32'hFFFF_FFFF}};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`MTR_OFF_CTRL, `MTR_CTL_RESET, 32'hFFFF_FFFF);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rc(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    run(6'h20, NN, NN, 8'h00, `MTR_TT_I_MISS, 8'hFF, 5'h0C);
    run(6'h10, NN, NN, 8'h00, `MTR_TT_I_ACC_EXC, 8'h02, 5'h0C);
    run(6'h08, NN, NN, 8'h00, `MTR_TT_I_ACC_EXC, 8'h01, 5'h0C);
    run(6'h04, NN, NN, 8'h00, `MTR_TT_I_ACC_ERR, 8'h08, 5'h04);
    run(6'h02, NN, NN, 8'h00, `MTR_TT_I_ACC_ERR, 8'h10, 5'h04);
    run(6'h01, NN, NN, 8'h00, `MTR_TT_I_ACC_ERR, 8'h04, 5'h04);
    run(6'h00, H_MS, NN, 8'h00, `MTR_TT_D_MISS, 8'hFF, 5'h03);
    run(6'h00, H_AE, NN, 8'h00, `MTR_TT_D_ACC_EXC, 8'h02, 5'h03);
    run(6'h00, H_PP, NN, 8'h00, `MTR_TT_D_ACC_EXC, 8'h01, 5'h03);
    run(6'h00, H_PR, NN, 8'h40, `MTR_TT_D_PROT, 8'hFF, 5'h03);
    run(6'h00, NN, NN, 8'h01, `MTR_TT_PRIV_ACTION, 8'hFF, 5'h01);
    run(6'h00, H_VW, NN, 8'h00, `MTR_TT_VA_WATCH, 8'hFF, 5'h01);
    run(6'h00, H_PW, NN, 8'h00, `MTR_TT_PA_WATCH, 8'hFF, 5'h01);
    run(6'h00, NN, NN, 8'h02, `MTR_TT_MISALIGN, 8'hFF, 5'h01);
    run(6'h00, NN, NN, 8'h06, `MTR_TT_MIS_LDDF, 8'hFF, 5'h01);
    run(6'h00, NN, NN, 8'h0A, `MTR_TT_MIS_STDF, 8'hFF, 5'h01);
    run(6'h00, NN, NN, 8'h0E, `MTR_TT_MIS_LDQF, 8'hFF, 5'h01);
    run(6'h00, NN, NN, 8'h12, `MTR_TT_MISALIGN, 8'hFF, 5'h00);
    run(6'h00, H_UE, NN, 8'h00, `MTR_TT_D_ACC_ERR, 8'h08, 5'h01);
    run(6'h00, H_BT, NN, 8'h00, `MTR_TT_D_ACC_ERR, 8'h10, 5'h01);
    run(6'h00, H_MH, NN, 8'h00, `MTR_TT_D_ACC_ERR, 8'h04, 5'h01);
    run(6'h00, H_MH | H_PR | H_AE | H_PW, NN, 8'h00, `MTR_TT_D_ACC_ERR, 8'h04, 5'h01);
    run(6'h00, H_BT | H_MS, NN, 8'h00, `MTR_TT_D_MISS, 8'hFF, 5'h03);
    run(6'h00, H_PR | H_UE, NN, 8'h00, `MTR_TT_D_PROT, 8'hFF, 5'h03);
    run(6'h00, NN, H_MS, 8'h20, `MTR_TT_PAGE_CROSS, 8'hFF, 5'h11);
    run(6'h00, NN, H_MH | H_MS, 8'h20, `MTR_TT_D_ACC_ERR, 8'h04, 5'h11);
    run(6'h00, H_MS, H_MS, 8'h20, `MTR_TT_D_MISS, 8'hFF, 5'h03);
    run(6'h00, H_MS, H_VW, 8'h20, `MTR_TT_VA_WATCH, 8'hFF, 5'h11);
    wb(1'b1, `MTR_OFF_CTRL, 32'h0000_0001);
    rc(`MTR_OFF_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
    run(6'h00, H_MS, H_VW, 8'h20, `MTR_TT_D_MISS, 8'hFF, 5'h03);
    run(6'h20, H_MS, NN, 8'h00, `MTR_TT_I_MISS, 8'hFF, 5'h0C);
    run(6'h00, H_MS, NN, 8'h80, 9'h000, 8'hFF, 5'h00);
    end_sim;
  end

  initial begin
    #100000;
    num_errors = num_errors + 1;
    end_sim;
  end
endmodule
